// ==== rtl/gcm_core.sv ====
// Purpose: group control command decode, hold modes and master loss sequence
// Assumes: frame strobes come from the receiver on clk, already checked
// Notes: buffer D/N roles are selector bits; memory sees one zero-write per bit tick
`timescale 1ns/1ps
`default_nettype none
`include "gcm_defines.svh"

module gcm_core (
   input wire logic clk,
   input wire logic rst,
   input wire gcm_pkg::gcm_frame_t gc,
   input wire logic gc_valid,
   input wire logic df_valid,
   input wire logic [7:0] df_len,
   input wire logic in_req,
   input wire logic rup_set,
   input wire logic ind_ack,
   input wire logic no_res_clr,
   input wire logic [7:0] group_mask,
   input wire logic [7:0] rx_buf_len,
   input wire logic reserved_bit_check_disable,
   input wire logic payload_length_check_disable,
   input wire logic force_master_loss,
   output logic input_hold_mode_q,
   output logic output_hold_mode_q,
   output logic reply_next_valid_q,
   output logic received_next_valid_q,
   output logic rx_sel_q,
   output logic reply_sel_q,
   output logic [7:0] stored_cmd_q,
   output logic busy_q,
   output logic lock_q,
   output logic mem_wr_q,
   output logic [7:0] mem_addr_q,
   output logic deact_wr_q,
   output logic [1:0] deact_sap_q,
   output logic [7:0] req_addr_q,
   output logic reply_d_q,
   output logic no_resource_reply_q,
   output logic no_res_flag_q,
   output logic irq_out_upd_q,
   output logic irq_wd_q,
   output logic irq_ind_q,
   output logic irq_ml_q,
   output logic force_clear_q
);
   import gcm_pkg::*;

   localparam int BIT_CYC = `GCM_BIT_CYC;

   gcm_state_t st_q;
   logic ml_q, tick_q, rx_d_valid_q, force_d_q, force_pend_q;
   logic [7:0] cnt_q;
   logic [7:0] div_q;
   logic addressed, gc_ok, res_bad, gc_ml, gc_go;
   logic df_ok, df_short, df_long, df_full, in_ok;
   logic frz, unfrz, syn, unsyn, clr, rup_swap, rx_swap, ml_start;
   logic fsm_swap, fsm_cmdrst;

   ////////////////////////////////////////////////////////////////////////////
   // decode; frames and input requests are dropped while the sequencer runs
   always_comb
   begin
      addressed = (gc.sel == `GCM_SEL_ALL) || ((gc.sel & group_mask) != 8'h00);
      gc_ok = gc_valid && !busy_q && addressed
         && (payload_length_check_disable || gc.len == `GCM_GC_LEN);
      res_bad = !reserved_bit_check_disable && (gc.cmd[`GCM_BIT_RES0]
         || gc.cmd[`GCM_BIT_RES6] || gc.cmd[`GCM_BIT_RES7]);
      gc_ml = gc_ok && res_bad;
      gc_go = gc_ok && !res_bad;
      frz = gc_go && gc.cmd[`GCM_BIT_FREEZE];
      unfrz = gc_go && gc.cmd[`GCM_BIT_UNFREEZE];
      syn = gc_go && gc.cmd[`GCM_BIT_SYNC];
      unsyn = gc_go && gc.cmd[`GCM_BIT_UNSYNC];
      clr = gc_go && gc.cmd[`GCM_BIT_CLEAR];
      df_ok = df_valid && !busy_q;
      df_short = df_ok && (df_len < rx_buf_len);
      df_long = df_ok && (df_len > rx_buf_len);
      df_full = df_ok && (df_len == rx_buf_len);
      in_ok = (in_req && !busy_q) || df_short || df_full;
      rup_swap = reply_next_valid_q
         && (frz || unfrz || (in_ok && !input_hold_mode_q));
      rx_swap = (!output_hold_mode_q && df_full)
         || (output_hold_mode_q && (syn || unsyn) && rx_d_valid_q);
      ml_start = gc_ml || force_pend_q;
      fsm_swap = (st_q == GCM_SWAP) && tick_q;
      fsm_cmdrst = (st_q == GCM_CMDRST) && tick_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit clock enable
   always_ff @(posedge clk)
   begin
      if (rst || div_q == 8'(BIT_CYC - 1))
      begin
         div_q <= 8'h00;
      end
      else
      begin
         div_q <= div_q + 8'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      tick_q <= !rst && (div_q == 8'(BIT_CYC - 1));
   end

   ////////////////////////////////////////////////////////////////////////////
   // hold modes; unfreeze then freeze in one frame leaves hold set
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         input_hold_mode_q <= 1'b0;
         output_hold_mode_q <= 1'b0;
      end
      else
      begin
         if (frz)
         begin
            input_hold_mode_q <= 1'b1;
         end
         else if (unfrz)
         begin
            input_hold_mode_q <= 1'b0;
         end
         if (syn)
         begin
            output_hold_mode_q <= 1'b1;
         end
         else if (unsyn && output_hold_mode_q)
         begin
            output_hold_mode_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // buffer selectors and valid flags; a set beats a clear
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         reply_sel_q <= 1'b0;
         rx_sel_q <= 1'b0;
         reply_next_valid_q <= 1'b0;
         received_next_valid_q <= 1'b0;
         rx_d_valid_q <= 1'b0;
         stored_cmd_q <= `GCM_CMD_RESET;
      end
      else
      begin
         reply_sel_q <= reply_sel_q ^ rup_swap;
         reply_next_valid_q <= rup_set || (reply_next_valid_q && !rup_swap);
         rx_sel_q <= rx_sel_q ^ (rx_swap || fsm_swap);
         received_next_valid_q <= rx_swap || (received_next_valid_q && !ind_ack);
         rx_d_valid_q <= (df_full && output_hold_mode_q)
            || (rx_d_valid_q && !rx_swap && !fsm_swap);
         if (fsm_cmdrst)
         begin
            stored_cmd_q <= `GCM_CMD_RESET;
         end
         else if (gc_go && gc.cmd != stored_cmd_q)
         begin
            stored_cmd_q <= gc.cmd;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer: zero fill of D, then master loss steps on bit ticks
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= GCM_IDLE;
         ml_q <= 1'b0;
         cnt_q <= 8'h00;
         busy_q <= 1'b0;
      end
      else
      begin
         unique case (st_q)
            GCM_IDLE:
            begin
               cnt_q <= 8'h00;
               if (ml_start || clr)
               begin
                  st_q <= GCM_FILL;
                  ml_q <= ml_start;
                  busy_q <= 1'b1;
               end
            end
            GCM_FILL:
            begin
               if (tick_q)
               begin
                  cnt_q <= (cnt_q == rx_buf_len) ? 8'h00 : cnt_q + 8'h01;
                  if (cnt_q == rx_buf_len)
                  begin
                     st_q <= ml_q ? GCM_WAIT : GCM_IDLE;
                     busy_q <= ml_q;
                  end
               end
            end
            GCM_WAIT:
            begin
               if (tick_q)
               begin
                  cnt_q <= cnt_q + 8'h01;
                  if (cnt_q == `GCM_ML_FIX - 8'h01)
                  begin
                     st_q <= GCM_SWAP;
                  end
               end
            end
            GCM_SWAP:
            begin
               cnt_q <= 8'h00;
               if (tick_q)
               begin
                  st_q <= GCM_CMDRST;
               end
            end
            GCM_CMDRST:
            begin
               if (tick_q)
               begin
                  st_q <= GCM_DEACT;
               end
            end
            GCM_DEACT:
            begin
               if (tick_q)
               begin
                  cnt_q <= cnt_q + 8'h01;
                  if (cnt_q[2:0] == `GCM_SAP_CNT - 3'h1)
                  begin
                     st_q <= GCM_DONE;
                  end
               end
            end
            GCM_DONE:
            begin
               if (tick_q)
               begin
                  st_q <= GCM_IDLE;
                  busy_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // the force bit is a level that software holds; only its rising edge counts
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         force_d_q <= 1'b0;
         force_pend_q <= 1'b0;
      end
      else
      begin
         force_d_q <= force_master_loss;
         force_pend_q <= (force_master_loss && !force_d_q)
            || (force_pend_q && !(st_q == GCM_IDLE));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pulse outputs, their addresses and the sticky no resource flag
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mem_wr_q <= 1'b0;
         mem_addr_q <= 8'h00;
         deact_wr_q <= 1'b0;
         deact_sap_q <= 2'h0;
         req_addr_q <= `GCM_REQ_DEACT;
         lock_q <= 1'b0;
         reply_d_q <= 1'b0;
         no_resource_reply_q <= 1'b0;
         no_res_flag_q <= 1'b0;
         irq_out_upd_q <= 1'b0;
         irq_wd_q <= 1'b0;
         irq_ind_q <= 1'b0;
         irq_ml_q <= 1'b0;
         force_clear_q <= 1'b0;
      end
      else
      begin
         mem_wr_q <= (st_q == GCM_FILL) && tick_q && (cnt_q != rx_buf_len);
         mem_addr_q <= cnt_q;
         deact_wr_q <= (st_q == GCM_DEACT) && tick_q;
         deact_sap_q <= cnt_q[1:0];
         req_addr_q <= `GCM_REQ_DEACT;
         lock_q <= rup_swap || rx_swap || fsm_swap || ((st_q == GCM_DEACT) && tick_q);
         reply_d_q <= in_ok;
         no_resource_reply_q <= df_long;
         no_res_flag_q <= df_long || (no_res_flag_q && !no_res_clr);
         irq_out_upd_q <= rx_swap
            || ((st_q == GCM_FILL) && !ml_q && tick_q && cnt_q == rx_buf_len);
         irq_wd_q <= df_full && output_hold_mode_q;
         irq_ind_q <= gc_go && (gc.cmd != stored_cmd_q);
         irq_ml_q <= (st_q == GCM_DONE) && tick_q;
         force_clear_q <= (st_q == GCM_DONE) && tick_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_res_ml;
      gc_ml |=> st_q == GCM_FILL && ml_q;
   endproperty
   a_res_ml: assert property (p_res_ml) else $error("reserved bits missed");

   property p_clear;
      clr && !ml_start |=> st_q == GCM_FILL && !ml_q;
   endproperty
   a_clear: assert property (p_clear) else $error("clear not started");

   property p_unfreeze;
      unfrz && !frz && !rup_set |=> !input_hold_mode_q && !reply_next_valid_q;
   endproperty
   a_unfreeze: assert property (p_unfreeze) else $error("unfreeze wrong");

   property p_freeze;
      frz && reply_next_valid_q |=> input_hold_mode_q && reply_sel_q != $past(reply_sel_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("freeze wrong");

   property p_hold_in;
      in_ok && input_hold_mode_q && !frz && !unfrz |=> $stable(reply_sel_q) && reply_d_q;
   endproperty
   a_hold_in: assert property (p_hold_in) else $error("held reply swapped");

   property p_unsync_idle;
      unsyn && !syn && !output_hold_mode_q && !df_full |=> $stable(rx_sel_q) && !irq_out_upd_q;
   endproperty
   a_unsync_idle: assert property (p_unsync_idle) else $error("unsync acted");

   property p_group;
      gc_valid && !fsm_cmdrst && gc.sel != 8'h00 && (gc.sel & group_mask) == 8'h00
         |=> !irq_ind_q && $stable(stored_cmd_q);
   endproperty
   a_group: assert property (p_group) else $error("unaddressed frame taken");

   property p_done;
      st_q == GCM_DONE && tick_q |=> irq_ml_q && force_clear_q && stored_cmd_q == 8'hFF;
   endproperty
   a_done: assert property (p_done) else $error("master loss end wrong");

   property p_long;
      df_long |=> no_resource_reply_q && no_res_flag_q
         ##1 no_resource_reply_q == $past(df_long);
   endproperty
   a_long: assert property (p_long) else $error("no resource missing");

   property p_ml_noirq;
      st_q == GCM_SWAP && tick_q |=> !irq_out_upd_q && lock_q;
   endproperty
   a_ml_noirq: assert property (p_ml_noirq) else $error("swap irq wrong");

   c_ml: cover property (irq_ml_q);
   c_sync: cover property (syn && output_hold_mode_q && rx_d_valid_q);
   c_freeze: cover property (frz ##[1:20] in_ok);
endmodule
`default_nettype wire

// ==== rtl/gcm_defines.svh ====
// Purpose: constants of the group control and master loss block
// Assumes: 100 MHz clk, bus bit clock 12 MHz
// Notes: byte values and bit positions of the command byte
`ifndef GCM_DEFINES_SVH
`define GCM_DEFINES_SVH
`define GCM_BIT_RES0 0
`define GCM_BIT_CLEAR 1
`define GCM_BIT_UNFREEZE 2
`define GCM_BIT_FREEZE 3
`define GCM_BIT_UNSYNC 4
`define GCM_BIT_SYNC 5
`define GCM_BIT_RES6 6
`define GCM_BIT_RES7 7
`define GCM_GC_LEN 8'h02
`define GCM_SEL_ALL 8'h00
`define GCM_CMD_RESET 8'hFF
`define GCM_REQ_DEACT 8'h7F
`define GCM_FILL_BYTE 8'h00
`define GCM_SAP_CNT 3'h4
`define GCM_ML_FIX 8'h12
`define GCM_CLK_PS 10000
`define GCM_BIT_PS 83333
`define GCM_BIT_CYC ((`GCM_BIT_PS / `GCM_CLK_PS) < 1 ? 1 : (`GCM_BIT_PS / `GCM_CLK_PS))
`endif

// ==== rtl/gcm_pkg.sv ====
// Purpose: types of the group control and master loss block
// Assumes: nothing
// Notes: frame fields travel as one struct
package gcm_pkg;
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] sel;
      logic [7:0] len;
   } gcm_frame_t;
   typedef enum logic [2:0] {GCM_IDLE, GCM_FILL, GCM_WAIT, GCM_SWAP, GCM_CMDRST, GCM_DEACT,
      GCM_DONE} gcm_state_t;
endpackage

// ==== bench/gcm_mst.sv ====
// Purpose: master station model that offers decoded frames to the block
// Assumes: each frame reaches the block as a one-cycle strobe
// Notes: fields are inverted outside frames so stale values never match
`timescale 1ns/1ps
`default_nettype none
module gcm_mst (
   input wire logic clk,
   output var gcm_pkg::gcm_frame_t gc,
   output logic gc_valid,
   output logic df_valid,
   output logic [7:0] df_len,
   output logic in_req
);
   import gcm_pkg::*;
   initial
   begin
      gc = '0;
      gc_valid = 1'b0;
      df_valid = 1'b0;
      df_len = 8'h00;
      in_req = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   // each task returns at the falling edge after the answer edge
   task automatic send_gc(input logic [7:0] c, input logic [7:0] s, input logic [7:0] l);
      @(negedge clk);
      gc = {c, s, l};
      gc_valid = 1'b1;
      @(negedge clk);
      gc_valid = 1'b0;
      gc = ~gc;
   endtask
   task automatic send_df(input logic [7:0] l);
      @(negedge clk);
      df_len = l;
      df_valid = 1'b1;
      @(negedge clk);
      df_valid = 1'b0;
      df_len = ~df_len;
   endtask
   task automatic send_req;
      @(negedge clk);
      in_req = 1'b1;
      @(negedge clk);
      in_req = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== bench/group_control_master_loss_tb.sv ====
// Purpose: self-checking bench of the group control and master loss block
// Assumes: receive buffer length of four bytes keeps sequences short
// Notes: pulse counters are sampled one edge late, hence the extra wait
`timescale 1ns/1ps
`default_nettype none
`include "gcm_defines.svh"
module group_control_master_loss_tb;
   import gcm_pkg::*;
   localparam logic [7:0] N = 8'h04;
   localparam int BC = `GCM_BIT_CYC;
   logic clk, rst, gv, dv, iq, rup_set, ind_ack, no_res_clr, rb_dis, pl_dis, force_ml;
   gcm_frame_t gc;
   logic [7:0] dl, group_mask, scmd, maddr, raddr;
   logic [1:0] dsap;
   logic ihm, ohm, rnv, xnv, xsel, psel, busy, lock, mwr, dwr, rpd, nrr, nrf;
   logic iou, iwd, iind, iml, fclr, r;
   int bad_count, n_compared, c_wr, c_dc, c_up, c_ml, c_fc, c_bz, c_oo;
   gcm_mst gcm_mst_i (.clk(clk), .gc(gc), .gc_valid(gv), .df_valid(dv), .df_len(dl),
      .in_req(iq));
   gcm_core gcm_core_i (.clk(clk), .rst(rst), .gc(gc), .gc_valid(gv), .df_valid(dv),
      .df_len(dl), .in_req(iq), .rup_set(rup_set), .ind_ack(ind_ack),
      .no_res_clr(no_res_clr), .group_mask(group_mask), .rx_buf_len(N),
      .reserved_bit_check_disable(rb_dis), .payload_length_check_disable(pl_dis),
      .force_master_loss(force_ml), .input_hold_mode_q(ihm), .output_hold_mode_q(ohm),
      .reply_next_valid_q(rnv), .received_next_valid_q(xnv), .rx_sel_q(xsel),
      .reply_sel_q(psel), .stored_cmd_q(scmd), .busy_q(busy), .lock_q(lock),
      .mem_wr_q(mwr), .mem_addr_q(maddr), .deact_wr_q(dwr), .deact_sap_q(dsap),
      .req_addr_q(raddr), .reply_d_q(rpd), .no_resource_reply_q(nrr),
      .no_res_flag_q(nrf), .irq_out_upd_q(iou), .irq_wd_q(iwd), .irq_ind_q(iind),
      .irq_ml_q(iml), .force_clear_q(fclr));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      // writes must walk the addresses and access points upwards from zero
      if (mwr && maddr != 8'(c_wr))
         c_oo++;
      if (dwr && dsap != 2'(c_dc))
         c_oo++;
      c_wr += mwr;
      c_dc += dwr;
      c_up += iou;
      c_ml += iml;
      c_fc += fclr;
      c_bz += busy;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic zero;
      c_wr = 0;
      c_dc = 0;
      c_up = 0;
      c_ml = 0;
      c_fc = 0;
      c_bz = 0;
      c_oo = 0;
   endtask
   task automatic wait_idle;
      int k;
      for (k = 0; k < 2000 && busy !== 1'b0; k++)
         @(negedge clk);
      @(negedge clk);
      chk(k < 2000, 1'b1);
   endtask
   task automatic test_done;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_hold;
      rup_set = 1'b1;
      @(negedge clk);
      rup_set = 1'b0;
      r = psel;
      gcm_mst_i.send_gc(8'h08, 8'h00, 8'h02);
      chk({ihm, psel, rnv, iind, lock}, {1'b1, ~r, 3'b011});
      chk(scmd, 8'h08);
      rup_set = 1'b1;
      @(negedge clk);
      rup_set = 1'b0;
      gcm_mst_i.send_req;
      chk({rpd, psel, rnv}, {1'b1, ~r, 1'b1});
      gcm_mst_i.send_gc(8'h04, 8'h00, 8'h02);
      chk({ihm, psel, rnv, iind}, {1'b0, r, 2'b01});
      rup_set = 1'b1;
      @(negedge clk);
      rup_set = 1'b0;
      gcm_mst_i.send_req;
      chk({rpd, psel, rnv}, {1'b1, ~r, 1'b0});
      gcm_mst_i.send_gc(8'h04, 8'h00, 8'h02);
      chk(iind, 1'b0);
      $display("hold test done");
   endtask
   task automatic t_group;
      group_mask = 8'h01;
      gcm_mst_i.send_gc(8'h08, 8'h02, 8'h02);
      chk(ihm, 1'b0);
      gcm_mst_i.send_gc(8'h08, 8'h03, 8'h02);
      chk(ihm, 1'b1);
      gcm_mst_i.send_gc(8'h04, 8'h01, 8'h03);
      chk(ihm, 1'b1);
      pl_dis = 1'b1;
      gcm_mst_i.send_gc(8'h04, 8'h01, 8'h03);
      chk(ihm, 1'b0);
      pl_dis = 1'b0;
      $display("group test done");
   endtask
   task automatic t_sync;
      r = xsel;
      gcm_mst_i.send_gc(8'h10, 8'h00, 8'h02);
      chk({ohm, xsel, iou}, {1'b0, r, 1'b0});
      gcm_mst_i.send_gc(8'h20, 8'h00, 8'h02);
      chk({ohm, xsel}, {1'b1, r});
      gcm_mst_i.send_df(N);
      chk({iwd, xsel}, {1'b1, r});
      gcm_mst_i.send_gc(8'h20, 8'h00, 8'h02);
      chk({xsel, xnv, iou, iind}, {~r, 3'b110});
      ind_ack = 1'b1;
      @(negedge clk);
      ind_ack = 1'b0;
      chk(xnv, 1'b0);
      gcm_mst_i.send_df(N);
      gcm_mst_i.send_gc(8'h10, 8'h00, 8'h02);
      chk({ohm, xsel, xnv, iou}, {1'b0, r, 2'b11});
      gcm_mst_i.send_df(N);
      chk({xsel, iou}, {~r, 1'b1});
      $display("sync test done");
   endtask
   task automatic t_frame;
      gcm_mst_i.send_df(N - 8'h01);
      chk({rpd, busy, nrr}, 3'b100);
      gcm_mst_i.send_df(N + 8'h01);
      chk({nrr, nrf}, 2'b11);
      no_res_clr = 1'b1;
      @(negedge clk);
      no_res_clr = 1'b0;
      @(negedge clk);
      chk(nrf, 1'b0);
      $display("frame test done");
   endtask
   task automatic t_clear;
      zero;
      gcm_mst_i.send_gc(8'h02, 8'h00, 8'h02);
      chk(busy, 1'b1);
      wait_idle;
      chk({c_wr[7:0], c_up[7:0], c_ml[7:0]}, {N, 16'h0100});
      chk(c_oo, 32'h0);
      $display("clear test done");
   endtask
   task automatic rb_one(input logic [7:0] c);
      gcm_mst_i.send_gc(c, 8'h00, 8'h02);
      chk(busy, 1'b1);
      wait_idle;
   endtask
   task automatic t_resbits;
      rb_one(8'h01);
      rb_one(8'h40);
      rb_one(8'h80);
      rb_dis = 1'b1;
      gcm_mst_i.send_gc(8'hC1, 8'h00, 8'h02);
      chk({busy, scmd}, 9'h0C1);
      rb_dis = 1'b0;
      $display("reserved bit test done");
   endtask
   task automatic t_force;
      zero;
      r = xsel;
      force_ml = 1'b1;
      repeat (20) @(negedge clk);
      gcm_mst_i.send_gc(8'h08, 8'h00, 8'h02);
      wait_idle;
      force_ml = 1'b0;
      chk({c_wr[7:0], xsel, c_up[7:0]}, {N, ~r, 8'h00});
      chk(scmd, 8'hFF);
      chk({c_dc[7:0], raddr, c_ml[7:0]}, 24'h047F01);
      chk(c_oo, 32'h0);
      chk(c_fc, 16'h0001);
      chk(c_bz >= (25 + N) * BC && c_bz <= (30 + N * 3 / 2 + 1) * BC, 1'b1);
      $display("master loss test done");
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      {rup_set, ind_ack, no_res_clr, rb_dis, pl_dis, force_ml} = 6'h00;
      group_mask = 8'h00;
      bad_count = 0;
      n_compared = 0;
      zero;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      chk({scmd, raddr, busy}, 17'h1FEFE);
      t_hold;
      t_group;
      t_sync;
      t_frame;
      t_clear;
      t_resbits;
      t_force;
      test_done;
   end
   // about 1100 cycles are needed, so this leaves a wide margin
   initial
   begin
      #200000;
      bad_count++;
      test_done;
   end
endmodule
`default_nettype wire
